//--- common/txirq_pkg.sv
// types for the transceiver interrupt logic
// assumes the constants header is on the include path
`include "txirq_regs.svh"
package txirq_pkg;
	typedef logic [`TXIRQ_NSRC-1:0] txirq_vec_t;
	typedef struct packed {
		logic pllUnlock;
		logic ramOverrun;
		logic txDone;
		logic arbBusy;
		logic rxDone;
		logic overrun;
		logic underrun;
		logic attention;
		logic powerUpDone;
		logic pktRcvd;
		logic rxWord;
		logic pktSent;
		logic txReady;
		logic ccaDone;
		logic compareOneHit;
		logic compareTwoHit;
		logic streamCompareHit;
		logic compareThreeHit;
		logic compareFourHit;
	} txirq_ev_t;
	typedef struct packed {
		logic statusRead;
		logic lengthRead;
		logic rxDataRead;
		logic txDataWrite;
		logic compareTwoOff;
		logic compareThreeOff;
		logic compareFourOff;
	} txirq_acc_t;
endpackage

//--- common/txirq_regs.svh
// constants for the transceiver interrupt logic
// assumes inclusion by the package and the design file only
`ifndef TXIRQ_REGS_SVH
`define TXIRQ_REGS_SVH
`define TXIRQ_NSRC       13
`define TXIRQ_B_PLL      0
`define TXIRQ_B_RAMTX    1
`define TXIRQ_B_ARBRX    2
`define TXIRQ_B_STRM     3
`define TXIRQ_B_ATTN     4
`define TXIRQ_B_DOZE     5
`define TXIRQ_B_RX       6
`define TXIRQ_B_TX       7
`define TXIRQ_B_CCA      8
`define TXIRQ_B_CMP1     9
`define TXIRQ_B_CMP2     10
`define TXIRQ_B_CMP3     11
`define TXIRQ_B_CMP4     12
`define TXIRQ_MASK_RST   13'h0010
`endif

//--- logic/txirq_logic.sv
// interrupt flag and request logic of the transceiver
// assumes events and host accesses as one-cycle pulses on clk
`timescale 1ns/10ps
`default_nettype none
`include "txirq_regs.svh"

// Behaviour
// RULE1: enabled masked event sets flag, drives request
// RULE2: status read clears flags, releases request
// RULE3: host services every flag from one read
// RULE4: packet mode RAM overrun sets shared flag
// RULE5: stream mode transmit done sets shared flag
// RULE6: packet mode busy RAM access sets flag
// RULE7: stream mode receive done sets flag
// RULE8: receive stream overrun sets data error
// RULE9: transmit stream underrun sets data error
// RULE10: attention or power-up done sets attention
// RULE11: doze compare two match sets wake
// RULE12: packet received sets receive flag
// RULE13: stream receive flag cleared by length/data read
// RULE14: packet sent sets transmit flag
// RULE15: stream transmit flag cleared by data write
// RULE16: channel assessment done sets flag
// RULE17: compare one match sets flag
// RULE18: compare two/stream match, not in doze
// RULE19: compare off bits clear timer flags
// RULE20: flags set regardless of mask
// RULE21: reset enables attention mask
// RULE22: unlock flag aborts new operations
// RULE23: request is OR of each flag ANDed with its mask
module txirq_logic
	import txirq_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       streamMode,
	input  wire logic       rxStream,
	input  wire logic       txStream,
	input  wire logic       dozing,
	input  wire txirq_ev_t  events,
	input  wire txirq_acc_t access,
	input  wire txirq_vec_t maskWrite,
	input  wire logic       maskLoad,
	input  wire logic       opStart,
	output txirq_vec_t      statusFlags,
	output txirq_vec_t      maskBits,
	output logic            irqOutN,
	output logic            irqOutOe,
	output logic            opAbort,
	output logic            dozeExit
);

	// ****************************************
	// event decode
	// ****************************************
	txirq_vec_t flags_q, flags_d, setVec, clrVec, mask_q;
	logic       rxFirst_q;
	logic       irqN_q, oe_q, abort_q, wake_q;
	wire logic  pktMode   = !streamMode;
	wire logic  cmp2Match = events.compareTwoHit | (streamMode & events.streamCompareHit);
	wire logic  rxWordEv  = streamMode & rxStream & events.rxWord;
	wire logic  rxClrOcc  = rxFirst_q ? access.lengthRead : access.rxDataRead;

	always_comb begin
		setVec = '0;
		setVec[`TXIRQ_B_PLL]   = events.pllUnlock;
		setVec[`TXIRQ_B_RAMTX] = (pktMode & events.ramOverrun)     // see RULE4
			| (streamMode & events.txDone);                        // see RULE5
		setVec[`TXIRQ_B_ARBRX] = (pktMode & events.arbBusy)        // see RULE6
			| (streamMode & events.rxDone);                        // see RULE7
		setVec[`TXIRQ_B_STRM]  = (streamMode & rxStream & events.overrun)  // see RULE8
			| (streamMode & txStream & events.underrun);               // see RULE9
		setVec[`TXIRQ_B_ATTN]  = events.attention | events.powerUpDone; // see RULE10
		setVec[`TXIRQ_B_DOZE]  = dozing & events.compareTwoHit;    // see RULE11
		setVec[`TXIRQ_B_RX]    = (pktMode & events.pktRcvd) | rxWordEv; // see RULE12
		setVec[`TXIRQ_B_TX]    = (pktMode & events.pktSent)        // see RULE14
			| (streamMode & txStream & events.txReady);
		setVec[`TXIRQ_B_CCA]   = events.ccaDone;                   // see RULE16
		setVec[`TXIRQ_B_CMP1]  = events.compareOneHit;             // see RULE17
		setVec[`TXIRQ_B_CMP2]  = cmp2Match & !dozing;              // see RULE18
		setVec[`TXIRQ_B_CMP3]  = events.compareThreeHit;
		setVec[`TXIRQ_B_CMP4]  = events.compareFourHit;
	end

	// ****************************************
	// clear decode
	// ****************************************
	always_comb begin
		clrVec = {`TXIRQ_NSRC{access.statusRead}};                 // see RULE2
		clrVec[`TXIRQ_B_RX]   = access.statusRead
			| (streamMode & rxStream & rxClrOcc);                  // see RULE13
		clrVec[`TXIRQ_B_TX]   = access.statusRead
			| (streamMode & txStream & access.txDataWrite);        // see RULE15
		clrVec[`TXIRQ_B_CMP2] = access.statusRead | access.compareTwoOff;   // see RULE19
		clrVec[`TXIRQ_B_CMP3] = access.statusRead | access.compareThreeOff; // see RULE19
		clrVec[`TXIRQ_B_CMP4] = access.statusRead | access.compareFourOff;  // see RULE19
	end

	// set wins over clear; mask plays no part here
	assign flags_d = setVec | (flags_q & ~clrVec);                 // see RULE20
	wire logic reqNext = |(flags_d & mask_q);                      // see RULE23

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_q <= '0;
		end else begin
			flags_q <= flags_d;                                    // see RULE1
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mask_q <= `TXIRQ_MASK_RST;                             // see RULE21
		end else if (maskLoad) begin
			mask_q <= maskWrite;
		end
	end

	// first stream word after a length read is data
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxFirst_q <= 1'b1;
		end else if (!(streamMode & rxStream)) begin
			rxFirst_q <= 1'b1;
		end else if (access.lengthRead) begin
			rxFirst_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irqN_q  <= 1'b1;
			oe_q    <= 1'b0;
			abort_q <= 1'b0;
			wake_q  <= 1'b0;
		end else begin
			irqN_q  <= !reqNext;                                   // see RULE1
			oe_q    <= reqNext;
			abort_q <= opStart & flags_q[`TXIRQ_B_PLL];            // see RULE22
			wake_q  <= dozing & events.compareTwoHit;              // see RULE11
		end
	end

	assign statusFlags = flags_q;
	assign maskBits    = mask_q;
	assign irqOutN     = irqN_q;
	assign irqOutOe    = oe_q;
	assign opAbort     = abort_q;
	assign dozeExit    = wake_q;

	// ****************************************
	// checks
	// ****************************************
	irq_tracks_flags_a: assert property (@(posedge clk) disable iff (rst) // see RULE23
		irqOutN == !(|(flags_q & mask_q)) || $past(maskLoad))
		else $error("request does not follow flags and mask");
	read_clears_a: assert property (@(posedge clk) disable iff (rst) // see RULE2
		access.statusRead && !(|setVec) |=> flags_q == '0 && irqOutN)
		else $error("status read did not clear");
	set_wins_a: assert property (@(posedge clk) disable iff (rst) // see RULE20
		setVec[`TXIRQ_B_CCA] |=> flags_q[`TXIRQ_B_CCA])
		else $error("event lost");
	held_until_read_a: assert property (@(posedge clk) disable iff (rst) // see RULE1
		flags_q[`TXIRQ_B_ATTN] && !access.statusRead |=> flags_q[`TXIRQ_B_ATTN])
		else $error("attention flag dropped early");
	doze_no_cmp2_a: assert property (@(posedge clk) disable iff (rst) // see RULE18
		dozing && !flags_q[`TXIRQ_B_CMP2] && !events.streamCompareHit |=> !flags_q[`TXIRQ_B_CMP2])
		else $error("compare two flag set while dozing");
	cmp_off_clear_a: assert property (@(posedge clk) disable iff (rst) // see RULE19
		access.compareThreeOff && !events.compareThreeHit |=> !flags_q[`TXIRQ_B_CMP3])
		else $error("compare off did not clear");
	unlock_abort_a: assert property (@(posedge clk) disable iff (rst) // see RULE22
		opStart && flags_q[`TXIRQ_B_PLL] |=> opAbort)
		else $error("operation not aborted");
	tx_write_clear_a: assert property (@(posedge clk) disable iff (rst) // see RULE15
		streamMode && txStream && access.txDataWrite && !setVec[`TXIRQ_B_TX]
		|=> !flags_q[`TXIRQ_B_TX])
		else $error("transmit write did not clear");
	oe_matches_a: assert property (@(posedge clk) disable iff (rst) // see RULE1
		irqOutOe == !irqOutN)
		else $error("enable and level disagree");

	// ****************************************
	// source set checks
	// ****************************************
	pll_set_a: assert property (@(posedge clk) disable iff (rst) // see RULE1
		events.pllUnlock |=> flags_q[`TXIRQ_B_PLL])
		else $error("unlock flag not set");
	ram_err_set_a: assert property (@(posedge clk) disable iff (rst) // see RULE4
		!streamMode && events.ramOverrun |=> flags_q[`TXIRQ_B_RAMTX])
		else $error("ram error flag not set");
	tx_done_set_a: assert property (@(posedge clk) disable iff (rst) // see RULE5
		streamMode && events.txDone |=> flags_q[`TXIRQ_B_RAMTX])
		else $error("transmit done flag not set");
	tx_done_pkt_a: assert property (@(posedge clk) disable iff (rst) // see RULE5
		!streamMode && !events.ramOverrun && !flags_q[`TXIRQ_B_RAMTX]
		|=> !flags_q[`TXIRQ_B_RAMTX])
		else $error("shared flag set without packet cause");
	arb_busy_set_a: assert property (@(posedge clk) disable iff (rst) // see RULE6
		!streamMode && events.arbBusy |=> flags_q[`TXIRQ_B_ARBRX])
		else $error("busy flag not set");
	rx_done_set_a: assert property (@(posedge clk) disable iff (rst) // see RULE7
		streamMode && events.rxDone |=> flags_q[`TXIRQ_B_ARBRX])
		else $error("receive done flag not set");
	rx_done_pkt_a: assert property (@(posedge clk) disable iff (rst) // see RULE7
		!streamMode && !events.arbBusy && !flags_q[`TXIRQ_B_ARBRX]
		|=> !flags_q[`TXIRQ_B_ARBRX])
		else $error("shared flag set without packet cause");
	overrun_set_a: assert property (@(posedge clk) disable iff (rst) // see RULE8
		streamMode && rxStream && events.overrun |=> flags_q[`TXIRQ_B_STRM])
		else $error("overrun not flagged");
	no_stream_err_a: assert property (@(posedge clk) disable iff (rst) // see RULE8
		!streamMode && !flags_q[`TXIRQ_B_STRM] |=> !flags_q[`TXIRQ_B_STRM])
		else $error("data error outside stream mode");
	underrun_set_a: assert property (@(posedge clk) disable iff (rst) // see RULE9
		streamMode && txStream && events.underrun |=> flags_q[`TXIRQ_B_STRM])
		else $error("underrun not flagged");
	attn_set_a: assert property (@(posedge clk) disable iff (rst) // see RULE10
		events.attention || events.powerUpDone |=> flags_q[`TXIRQ_B_ATTN])
		else $error("attention flag not set");
	doze_wake_a: assert property (@(posedge clk) disable iff (rst) // see RULE11
		dozing && events.compareTwoHit |=> flags_q[`TXIRQ_B_DOZE] && dozeExit)
		else $error("doze wake missing");
	wake_pulse_a: assert property (@(posedge clk) disable iff (rst) // see RULE11
		!(dozing && events.compareTwoHit) |=> !dozeExit)
		else $error("doze exit without cause");
	no_doze_flag_a: assert property (@(posedge clk) disable iff (rst) // see RULE11
		!dozing && !flags_q[`TXIRQ_B_DOZE] |=> !flags_q[`TXIRQ_B_DOZE])
		else $error("doze flag set while awake");
	pkt_rcvd_set_a: assert property (@(posedge clk) disable iff (rst) // see RULE12
		!streamMode && events.pktRcvd |=> flags_q[`TXIRQ_B_RX])
		else $error("packet received flag not set");
	rx_idle_stream_a: assert property (@(posedge clk) disable iff (rst) // see RULE12
		streamMode && !rxStream && !flags_q[`TXIRQ_B_RX] |=> !flags_q[`TXIRQ_B_RX])
		else $error("receive flag set outside receive");
	rx_stream_set_a: assert property (@(posedge clk) disable iff (rst) // see RULE13
		rxWordEv |=> flags_q[`TXIRQ_B_RX])
		else $error("stream word not flagged");
	rx_length_clear_a: assert property (@(posedge clk) disable iff (rst) // see RULE13
		streamMode && rxStream && rxFirst_q && access.lengthRead && !setVec[`TXIRQ_B_RX]
		|=> !flags_q[`TXIRQ_B_RX])
		else $error("length read did not clear");
	rx_data_clear_a: assert property (@(posedge clk) disable iff (rst) // see RULE13
		streamMode && rxStream && !rxFirst_q && access.rxDataRead && !setVec[`TXIRQ_B_RX]
		|=> !flags_q[`TXIRQ_B_RX])
		else $error("data read did not clear");
	rx_first_reset_a: assert property (@(posedge clk) disable iff (rst) // see RULE13
		!(streamMode && rxStream) |=> rxFirst_q)
		else $error("first word marker not restored");
	pkt_sent_set_a: assert property (@(posedge clk) disable iff (rst) // see RULE14
		!streamMode && events.pktSent |=> flags_q[`TXIRQ_B_TX])
		else $error("packet sent flag not set");
	tx_idle_stream_a: assert property (@(posedge clk) disable iff (rst) // see RULE14
		streamMode && !txStream && !flags_q[`TXIRQ_B_TX] |=> !flags_q[`TXIRQ_B_TX])
		else $error("transmit flag set outside transmit");
	tx_ready_set_a: assert property (@(posedge clk) disable iff (rst) // see RULE15
		streamMode && txStream && events.txReady |=> flags_q[`TXIRQ_B_TX])
		else $error("transmit ready not flagged");
	tx_clear_pkt_a: assert property (@(posedge clk) disable iff (rst) // see RULE15
		!streamMode && flags_q[`TXIRQ_B_TX] && !access.statusRead |=> flags_q[`TXIRQ_B_TX])
		else $error("transmit flag cleared in packet mode");
	cmp1_set_a: assert property (@(posedge clk) disable iff (rst) // see RULE17
		events.compareOneHit |=> flags_q[`TXIRQ_B_CMP1])
		else $error("compare one flag not set");
	cmp1_no_off_a: assert property (@(posedge clk) disable iff (rst) // see RULE19
		flags_q[`TXIRQ_B_CMP1] && !access.statusRead |=> flags_q[`TXIRQ_B_CMP1])
		else $error("compare one flag dropped");
	cmp2_set_a: assert property (@(posedge clk) disable iff (rst) // see RULE18
		!dozing && (events.compareTwoHit || (streamMode && events.streamCompareHit))
		|=> flags_q[`TXIRQ_B_CMP2])
		else $error("compare two flag not set");

	// ****************************************
	// clear checks
	// ****************************************
	cmp2_off_clear_a: assert property (@(posedge clk) disable iff (rst) // see RULE19
		access.compareTwoOff && !setVec[`TXIRQ_B_CMP2] |=> !flags_q[`TXIRQ_B_CMP2])
		else $error("compare two off did not clear");
	cmp4_off_clear_a: assert property (@(posedge clk) disable iff (rst) // see RULE19
		access.compareFourOff && !events.compareFourHit |=> !flags_q[`TXIRQ_B_CMP4])
		else $error("compare four off did not clear");
	pll_holds_a: assert property (@(posedge clk) disable iff (rst) // see RULE22
		flags_q[`TXIRQ_B_PLL] && !access.statusRead |=> flags_q[`TXIRQ_B_PLL])
		else $error("unlock flag dropped early");
	no_abort_a: assert property (@(posedge clk) disable iff (rst) // see RULE22
		!(opStart && flags_q[`TXIRQ_B_PLL]) |=> !opAbort)
		else $error("abort without unlock");
	for (genvar i = 0; i < `TXIRQ_NSRC; i++) begin : gFlagChk
		read_clear_bit_a: assert property (@(posedge clk) disable iff (rst) // see RULE2
			access.statusRead && !setVec[i] |=> !flags_q[i])
			else $error("status read left a flag set");
		flag_sticky_a: assert property (@(posedge clk) disable iff (rst) // see RULE20
			flags_q[i] && !clrVec[i] |=> flags_q[i])
			else $error("flag dropped without a clear");
	end

	// ****************************************
	// request checks
	// ****************************************
	irq_asserted_a: assert property (@(posedge clk) disable iff (rst) // see RULE23
		|(flags_d & mask_q) |=> !irqOutN)
		else $error("request not asserted");
	irq_released_a: assert property (@(posedge clk) disable iff (rst) // see RULE23
		!(|(flags_d & mask_q)) |=> irqOutN)
		else $error("request not released");
	mask_load_a: assert property (@(posedge clk) disable iff (rst) // see RULE23
		maskLoad |=> maskBits == $past(maskWrite))
		else $error("mask not loaded");
	mask_hold_a: assert property (@(posedge clk) disable iff (rst) // see RULE21
		!maskLoad |=> maskBits == $past(maskBits))
		else $error("mask changed without load");

endmodule
`default_nettype wire

//--- verif/txirq_host_model.sv
// host side of the open-drain request line
// assumes irqOutOe high while the design pulls the line low
`timescale 1ns/10ps
`default_nettype none
module txirq_host_model (
	input  wire logic irqOutN,
	input  wire logic irqOutOe,
	output wire logic irqLine
);
	// ****************
	// pull-up resolution
	// ****************
	// released line floats to the pull-up level
	assign irqLine = irqOutOe ? irqOutN : 1'b1;
endmodule
`default_nettype wire

//--- verif/txirq_logic_tb.sv
// self-checking bench for the interrupt flag logic
// assumes one clock, pulses driven 1 ns after the rising edge
`timescale 1ns/10ps
`default_nettype none
module txirq_logic_tb
	import txirq_pkg::*;
;
	logic       clk = 0, rst = 1, streamMode = 0, rxStream = 0, txStream = 0;
	logic       dozing = 0, maskLoad = 0, opStart = 0;
	txirq_ev_t  events = '0;
	txirq_acc_t access = '0;
	txirq_vec_t maskWrite = '0, statusFlags, maskBits;
	logic       irqOutN, irqOutOe, opAbort, dozeExit, irqLine;
	int         errors = 0, comparisons = 0;
	always #50 clk = ~clk;
	txirq_logic dut (.clk(clk), .rst(rst), .streamMode(streamMode), .rxStream(rxStream),
		.txStream(txStream), .dozing(dozing), .events(events), .access(access),
		.maskWrite(maskWrite), .maskLoad(maskLoad), .opStart(opStart),
		.statusFlags(statusFlags), .maskBits(maskBits), .irqOutN(irqOutN),
		.irqOutOe(irqOutOe), .opAbort(opAbort), .dozeExit(dozeExit));
	txirq_host_model host (.irqOutN(irqOutN), .irqOutOe(irqOutOe), .irqLine(irqLine));
	// ****************
	// tasks
	// ****************
	task check(input txirq_vec_t seen, input txirq_vec_t exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task step;
		@(posedge clk);
		#1;
	endtask
	task setMask(input txirq_vec_t v);
		maskWrite = v;
		maskLoad = 1;
		step;
		maskLoad = 0;
		step;
	endtask
	task ev(input int k, input logic [2:0] m, input int b, input int a);
		{streamMode, rxStream, txStream} = m;
		events = txirq_ev_t'(19'h1 << k);
		step;
		events = '0;
		check(statusFlags, 13'h1 << b);
		check(irqLine, 1'b0);
		access = txirq_acc_t'(7'h1 << a);
		step;
		access = '0;
		check(statusFlags, '0);
		check(irqLine, 1'b1);
	endtask
	task results;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		results;
	end
	initial begin
		repeat (4) @(posedge clk);
		#1 rst = 0;
		check(maskBits, 13'h0010);
		events.powerUpDone = 1;
		step;
		events = '0;
		check(irqLine, 1'b0);
		$display("test reset done");
		setMask('0);
		events.ccaDone = 1;
		events.compareOneHit = 1;
		step;
		events = '0;
		check(statusFlags, 13'h0310);
		check(irqLine, 1'b1);
		setMask(13'h0100);
		check(irqLine, 1'b0);
		setMask('1);
		access.statusRead = 1;
		step;
		access = '0;
		check(statusFlags, '0);
		ev(11, 3'd0, 4, 6);
		$display("test mask done");
		ev(18, 3'd0, 0, 6);
		ev(17, 3'd0, 1, 6);
		ev(16, 3'd5, 1, 6);
		ev(15, 3'd0, 2, 6);
		ev(14, 3'd6, 2, 6);
		ev(13, 3'd6, 3, 6);
		ev(12, 3'd5, 3, 6);
		ev(9, 3'd0, 6, 6);
		ev(8, 3'd6, 6, 5);
		ev(8, 3'd6, 6, 4);
		ev(7, 3'd0, 7, 6);
		ev(6, 3'd5, 7, 3);
		ev(5, 3'd0, 8, 6);
		ev(4, 3'd0, 9, 6);
		ev(2, 3'd6, 10, 6);
		ev(3, 3'd0, 10, 2);
		ev(1, 3'd0, 11, 1);
		ev(0, 3'd0, 12, 0);
		$display("test sources done");
		events.pllUnlock = 1;
		step;
		events = '0;
		opStart = 1;
		step;
		opStart = 0;
		check(opAbort, 1'b1);
		access.statusRead = 1;
		step;
		access = '0;
		opStart = 1;
		step;
		opStart = 0;
		check(opAbort, 1'b0);
		dozing = 1;
		events.compareTwoHit = 1;
		step;
		events = '0;
		dozing = 0;
		check(dozeExit, 1'b1);
		check(statusFlags, 13'h0020);
		$display("test abort and doze done");
		results;
	end
endmodule
`default_nettype wire
